/* File: hw/cgd_top.v */
// Clock gate and divider block: DMA clock gate register, core and
// bus/flash divider register, status register, APB slave.
// Assumes the mode and boot inputs come from logic on clock.
//
// Behaviour
// - Bit 8 of the gate register runs the DMA clock when 1 and stops it when 0.
// - Reserved bits of both registers are read-only and read as zero.
// - Writes to the divider register are ignored in very-low-power run.
// - At the end of reset the core field loads 0000, 0001, 0011 or 0111 from the boot bits.
// - The core clock divides by the core field plus one, ratios 1 to 16.
// - The bus/flash clock further divides by its field plus one, reset 001.
`timescale 1ns/1ps
`include "cgd_consts.vh"
`default_nettype none

module cgd_top
(
	// Clock and reset
	input wire clock,
	input wire resetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`CGD_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	// Power mode and boot option
	input wire very_low_power_run,
	input wire [1:0] low_power_boot_option,
	// DMA clock
	output wire dma_clock,
	output wire dma_clock_enable,
	// Divided clocks
	output reg core_clock_tick,
	output reg core_clock_phase,
	output reg bus_flash_clock_tick,
	output reg bus_flash_clock_phase,
	// Divider fields in use
	output wire [3:0] core_clock_divide_field,
	output wire [2:0] bus_flash_divide_field
);

// ==============================================================
// Decode functions
function [1:0] reg_select;
	input [`CGD_ADDR_W-1:0] addr;
	begin
		case (addr)
			`CGD_OFS_GATE: reg_select = `CGD_SEL_GATE;
			`CGD_OFS_DIV: reg_select = `CGD_SEL_DIV;
			`CGD_OFS_STAT: reg_select = `CGD_SEL_STAT;
			default: reg_select = `CGD_SEL_NONE;
		endcase
	end
endfunction

function [3:0] boot_core_code;
	input [1:0] boot;
	begin
		case (boot)
			`CGD_BOOT_DIV8: boot_core_code = `CGD_CORE_DIV8;
			`CGD_BOOT_DIV4: boot_core_code = `CGD_CORE_DIV4;
			`CGD_BOOT_DIV2: boot_core_code = `CGD_CORE_DIV2;
			default: boot_core_code = `CGD_CORE_DIV1;
		endcase
	end
endfunction

// ==============================================================
// Registers
reg dma_en_q;
reg [3:0] core_field_q;
reg [2:0] bus_field_q;
reg drop_q;
reg [3:0] core_ratio_q;
reg [3:0] core_cnt_q;
reg [3:0] core_cnt_d;
reg [2:0] bus_ratio_q;
reg [2:0] bus_cnt_q;
reg [2:0] bus_cnt_d;
reg [31:0] rdata_d;

wire setup_phase;
wire access_write;
wire [1:0] setup_sel;
wire [1:0] access_sel;
wire div_write;
wire div_write_ok;
wire drop_clear;
wire core_wrap;
wire bus_wrap;
reg [31:0] gate_rd;
reg [31:0] div_rd;
reg [31:0] stat_rd;
wire [4:0] core_half;
wire [3:0] bus_half;

// ==============================================================
// APB phases
assign setup_phase = psel & ~penable;
assign pready = psel & penable;
assign access_write = pready & pwrite;
assign setup_sel = reg_select(paddr);
assign access_sel = reg_select(paddr);

assign div_write = access_write & (access_sel == `CGD_SEL_DIV);
assign div_write_ok = div_write & ~very_low_power_run;
assign drop_clear = access_write & (access_sel == `CGD_SEL_STAT) & pwdata[`CGD_ST_DROP_BIT];

// ==============================================================
// Read views, reserved bits zero
always @*
begin
	gate_rd = `CGD_ZERO32;
	gate_rd[`CGD_DMA_BIT] = dma_en_q;
end

// Divider view, written fields only
always @*
begin
	div_rd = `CGD_ZERO32;
	div_rd[`CGD_CORE_MSB:`CGD_CORE_LSB] = core_field_q;
	div_rd[`CGD_BUS_MSB:`CGD_BUS_LSB] = bus_field_q;
end

// Status view: ratios in use, mode, dropped-write flag
always @*
begin
	stat_rd = `CGD_ZERO32;
	stat_rd[`CGD_ST_CORE_MSB:`CGD_ST_CORE_LSB] = core_ratio_q;
	stat_rd[`CGD_ST_BUS_MSB:`CGD_ST_BUS_LSB] = bus_ratio_q;
	stat_rd[`CGD_ST_LPRUN_BIT] = very_low_power_run;
	stat_rd[`CGD_ST_DROP_BIT] = drop_q;
end

always @*
begin
	case (setup_sel)
		`CGD_SEL_GATE: rdata_d = gate_rd;
		`CGD_SEL_DIV: rdata_d = div_rd;
		`CGD_SEL_STAT: rdata_d = stat_rd;
		default: rdata_d = `CGD_ZERO32;
	endcase
end

// Read data and error captured in setup, shown in access
always @(posedge clock)
begin
	if (!resetn)
	begin
		prdata <= `CGD_ZERO32;
		pslverr <= 1'b0;
	end
	else if (setup_phase)
	begin
		prdata <= pwrite ? `CGD_ZERO32 : rdata_d;
		pslverr <= (setup_sel == `CGD_SEL_NONE);
	end
end

// ==============================================================
// Gate register
always @(posedge clock)
begin
	if (!resetn)
	begin
		dma_en_q <= `CGD_DMA_RST;
	end
	else if (access_write && access_sel == `CGD_SEL_GATE)
	begin
		dma_en_q <= pwdata[`CGD_DMA_BIT];
	end
end

assign dma_clock_enable = dma_en_q;

cgd_clock_gate u_dma_gate
(
	.clk_in(clock),
	.enable(dma_en_q),
	.clk_out(dma_clock)
);

// ==============================================================
// Divider register
always @(posedge clock)
begin
	if (!resetn)
	begin
		core_field_q <= boot_core_code(low_power_boot_option);
		bus_field_q <= `CGD_BUS_RST;
	end
	else if (div_write_ok)
	begin
		core_field_q <= pwdata[`CGD_CORE_MSB:`CGD_CORE_LSB];
		bus_field_q <= pwdata[`CGD_BUS_MSB:`CGD_BUS_LSB];
	end
end

// Dropped-write flag, set wins over clear
always @(posedge clock)
begin
	if (!resetn)
	begin
		drop_q <= 1'b0;
	end
	else if (div_write && very_low_power_run)
	begin
		drop_q <= 1'b1;
	end
	else if (drop_clear)
	begin
		drop_q <= 1'b0;
	end
end

// ==============================================================
// Core divider, new ratio taken at wrap
assign core_wrap = (core_cnt_q == core_ratio_q);

always @*
begin
	if (core_wrap)
	begin
		core_cnt_d = 4'h0;
	end
	else
	begin
		core_cnt_d = core_cnt_q + 4'h1;
	end
end

// Phase high over the first half of the period
assign core_half = {1'b0, core_ratio_q} + 5'h01;

always @(posedge clock)
begin
	if (!resetn)
	begin
		core_cnt_q <= 4'h0;
		core_ratio_q <= boot_core_code(low_power_boot_option);
		core_clock_tick <= 1'b0;
		core_clock_phase <= 1'b0;
	end
	else
	begin
		core_cnt_q <= core_cnt_d;
		core_clock_tick <= core_wrap;
		core_clock_phase <= ({core_cnt_d, 1'b0} < core_half);
		if (core_wrap)
		begin
			core_ratio_q <= core_field_q;
		end
	end
end

assign core_clock_divide_field = core_ratio_q;

// ==============================================================
// Bus/flash divider, counts core periods
assign bus_wrap = core_wrap & (bus_cnt_q == bus_ratio_q);

always @*
begin
	if (!core_wrap)
	begin
		bus_cnt_d = bus_cnt_q;
	end
	else if (bus_wrap)
	begin
		bus_cnt_d = 3'h0;
	end
	else
	begin
		bus_cnt_d = bus_cnt_q + 3'h1;
	end
end

assign bus_half = {1'b0, bus_ratio_q} + 4'h1;

always @(posedge clock)
begin
	if (!resetn)
	begin
		bus_cnt_q <= 3'h0;
		bus_ratio_q <= `CGD_BUS_RST;
		bus_flash_clock_tick <= 1'b0;
		bus_flash_clock_phase <= 1'b0;
	end
	else
	begin
		bus_cnt_q <= bus_cnt_d;
		bus_flash_clock_tick <= bus_wrap;
		bus_flash_clock_phase <= ({bus_cnt_d, 1'b0} < bus_half);
		if (bus_wrap)
		begin
			bus_ratio_q <= bus_field_q;
		end
	end
end

assign bus_flash_divide_field = bus_ratio_q;

endmodule
`default_nettype wire

/* File: hw/cgd_consts.vh */
// Constants of the clock gate and divider block: register offsets,
// field positions, reset values and boot decode codes.
// Assumes a 16-bit APB byte address and 32-bit data.
`ifndef CGD_CONSTS_VH
`define CGD_CONSTS_VH

// ==============================================================
// Register byte offsets
`define CGD_ADDR_W 16
`define CGD_OFS_GATE 16'h1040
`define CGD_OFS_DIV 16'h1044
`define CGD_OFS_STAT 16'h1080

// ==============================================================
// Register selects returned by the address decode
`define CGD_SEL_NONE 2'h0
`define CGD_SEL_GATE 2'h1
`define CGD_SEL_DIV 2'h2
`define CGD_SEL_STAT 2'h3

// ==============================================================
// Field positions
`define CGD_DMA_BIT 8
`define CGD_CORE_MSB 31
`define CGD_CORE_LSB 28
`define CGD_BUS_MSB 18
`define CGD_BUS_LSB 16
`define CGD_ST_CORE_MSB 3
`define CGD_ST_CORE_LSB 0
`define CGD_ST_BUS_MSB 6
`define CGD_ST_BUS_LSB 4
`define CGD_ST_LPRUN_BIT 8
`define CGD_ST_DROP_BIT 9

// ==============================================================
// Reset values and boot decode
`define CGD_DMA_RST 1'h1
`define CGD_BUS_RST 3'h1
`define CGD_CORE_DIV1 4'h0
`define CGD_CORE_DIV2 4'h1
`define CGD_CORE_DIV4 4'h3
`define CGD_CORE_DIV8 4'h7
`define CGD_BOOT_DIV8 2'h0
`define CGD_BOOT_DIV4 2'h1
`define CGD_BOOT_DIV2 2'h2
`define CGD_ZERO32 32'h00000000

`endif

/* File: hw/cgd_clock_gate.v */
// Glitch-free clock gating cell for the DMA engine clock.
// Assumes the enable changes only on the rising edge of clk_in.
`timescale 1ns/1ps
`default_nettype none

module cgd_clock_gate
(
	// Clock in
	input wire clk_in,
	// Gate control
	input wire enable,
	// Gated clock out
	output wire clk_out
);

// ==============================================================
// Enable taken on the falling edge, held while the clock is high
reg enable_q;

always @(negedge clk_in)
begin
	enable_q <= enable;
end

// Held enable cannot change while clk_in is high
assign clk_out = clk_in & enable_q;

endmodule
`default_nettype wire

/* File: tb/cgd_monitor.sv */
// Port checker for cgd_top.
// Bound to cgd_top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`include "cgd_consts.vh"
`default_nettype none
// ====================
// Checker
module cgd_monitor
(
	// Clock and APB
	input wire logic clock,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Mode, boot and clocks
	input wire logic very_low_power_run,
	input wire logic [1:0] low_power_boot_option,
	input wire logic dma_clock,
	input wire logic dma_clock_enable,
	input wire logic core_clock_tick,
	input wire logic bus_flash_clock_tick,
	input wire logic [3:0] core_clock_divide_field,
	input wire logic [2:0] bus_flash_divide_field
);
	logic [3:0] c_q;
	logic [3:0] f_q;
	logic ok_q;
	wire logic acc = psel && penable;
	wire logic wd = acc && pwrite && paddr == `CGD_OFS_DIV;
	// Cycles since last core tick, valid over a whole steady period
	always @(posedge clock)
	begin
		f_q <= core_clock_divide_field;
		c_q <= core_clock_tick ? 4'h0 : c_q + 4'h1;
		ok_q <= resetn && (core_clock_tick || ok_q) && core_clock_divide_field == f_q;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	chk_gate_bit_write: assert property (acc && pwrite && paddr == `CGD_OFS_GATE
		|=> dma_clock_enable == $past(pwdata[8])) else $error("gate write lost");
	chk_reserved_zero: assert property (acc && !pwrite |->
		(paddr != `CGD_OFS_GATE || {prdata[31:9], prdata[7:0]} == 31'h0) &&
		(paddr != `CGD_OFS_DIV || prdata[27:19] == 9'h0)) else $error("reserved bit set");
	chk_lprun_drop: assert property (wd && very_low_power_run |=>
		($stable(core_clock_divide_field) && $stable(bus_flash_divide_field)) [*8])
		else $error("divider changed");
	chk_boot_load: assert property (disable iff (1'b0) !resetn |=>
		core_clock_divide_field == 4'h7 >> $past(low_power_boot_option) &&
		bus_flash_divide_field == 3'h1) else $error("reset divider wrong");
	chk_core_period: assert property (core_clock_tick && ok_q &&
		core_clock_divide_field == f_q |-> c_q == core_clock_divide_field)
		else $error("core period wrong");
	chk_bus_on_core: assert property (bus_flash_clock_tick |-> core_clock_tick)
		else $error("bus tick stray");
	chk_gate_glitch: assert property (@(negedge clock) $stable(dma_clock_enable)
		|-> dma_clock == dma_clock_enable) else $error("gated pulse wrong");
	cover property (wd && very_low_power_run);
	cover property (bus_flash_clock_tick);
	cover property (acc && pwrite && !pwdata[8]);
endmodule
bind cgd_top cgd_monitor u_mon (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .very_low_power_run, .low_power_boot_option, .dma_clock, .dma_clock_enable,
	.core_clock_tick, .bus_flash_clock_tick, .core_clock_divide_field, .bus_flash_divide_field);
`default_nettype wire

/* File: tb/tb_clock_gate_and_divider.sv */
// Bench for cgd_top: APB tasks, resets, tick timing.
// Assumes cgd_top and its bound checker.
`timescale 1ns/1ps
`include "cgd_consts.vh"
`default_nettype none
// ====================
// Bench
module tb_clock_gate_and_divider;
	logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, vl = 0, er;
	logic [1:0] bo = 2'h2;
	logic [15:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	wire [31:0] prdata;
	wire pready, pslverr, dck, den, ct, cp, bt, bp;
	int fails = 0, n_tests = 0;
	localparam logic [15:0] G = `CGD_OFS_GATE, D = `CGD_OFS_DIV, S = `CGD_OFS_STAT;
	cgd_top u_dut (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .very_low_power_run(vl), .low_power_boot_option(bo),
		.dma_clock(dck), .dma_clock_enable(den), .core_clock_tick(ct), .core_clock_phase(cp),
		.bus_flash_clock_tick(bt), .bus_flash_clock_phase(bp), .core_clock_divide_field(),
		.bus_flash_divide_field());
	task conclude();
		$display("fails=%0d tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do
		begin
			@(posedge clock);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rc(input logic [15:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(rd, e);
	endtask
	task rst(input logic [1:0] b, input int n);
		@(posedge clock);
		bo <= b;
		resetn <= 0;
		repeat (n) @(posedge clock);
		resetn <= 1;
	endtask
	// Cycles and phase-high cycles between two core ticks once the new ratio is applied
	task per(input int n);
		int k;
		int h;
		k = 0;
		h = 0;
		repeat (20) @(posedge clock);
		@(posedge clock iff ct === 1'b1);
		do
		begin
			@(posedge clock);
			k++;
			h += (cp === 1'b1);
		end
		while (ct !== 1'b1 && k < 40);
		chk(k, n);
		chk(h, (n + 1) / 2);
	endtask
	task t_gate();
		rc(G, 32'h100);
		apb(1, G, '1);
		rc(G, 32'h100);
		apb(1, G, 0);
		rc(G, 0);
		chk(den, 0);
		repeat (3)
		begin
			@(posedge clock);
			#10;
			chk(dck, 0);
		end
		apb(1, G, 32'h100);
		rc(G, 32'h100);
		@(posedge clock);
		#10;
		chk(dck, 1);
	endtask
	task t_div();
		apb(1, D, '1);
		rc(D, 32'hf007_0000);
		per(16);
		apb(1, D, 32'h2000_0000);
		per(3);
	endtask
	task t_lprun();
		// Let a pending bus ratio settle before the dropped write
		repeat (30) @(posedge clock);
		vl <= 1;
		apb(1, D, 0);
		rc(D, 32'h2000_0000);
		apb(0, S, 0);
		chk(rd & 32'h30f, 32'h302);
		vl <= 0;
		apb(1, S, 32'h200);
		apb(0, S, 0);
		chk(rd & 32'h30f, 32'h002);
		apb(1, D, 0);
		rc(D, 0);
		per(1);
		chk({bt, bp}, 2'b11);
	endtask
	task t_bad();
		apb(0, 16'h1000, 0);
		chk(er, 1);
		chk(rd, 0);
	endtask
	task t_boot();
		for (int b = 0; b < 4; b++)
		begin
			rst(b[1:0], 2);
			rc(D, {4'h7 >> b[1:0], 12'h001, 16'h0});
		end
	endtask
	initial
	begin
		forever #20 clock = ~clock;
	end
	initial
	begin
		#800000;
		fails++;
		conclude();
	end
	initial
	begin
		rst(2'h2, 20);
		t_gate();
		t_div();
		t_lprun();
		t_bad();
		t_boot();
		conclude();
	end
endmodule
`default_nettype wire
